// ### core/aip_core.sv
`timescale 1ns/1ps
`default_nettype none
module aip_core
  import aip_pkg::*;
#(
  parameter int          NUM_CH      = 4,
  parameter bit          EIGHT_CH    = 1'b0,
  parameter int unsigned WDOG_LIMIT  = WDOG_CYCLES,
  parameter logic [15:0] FACT_GAIN   = 16'h0100,
  parameter logic [15:0] FACT_OFFSET = 16'h0000,
  parameter int          SEL_W       = $clog2(NUM_CH)
)
(
  // clock and reset
  input  wire logic                       clk_sys,
  input  wire logic                       reset_n,
  // register access
  input  wire logic                       cfg_wr,
  input  wire logic                       cfg_rd,
  input  wire logic [SEL_W-1:0]           cfg_channel,
  input  wire logic [IDX_W-1:0]           cfg_index,
  input  wire logic [DATA_W-1:0]          cfg_wdata,
  output logic      [DATA_W-1:0]          cfg_rdata,
  output logic                            cfg_rvalid,
  // converter samples
  input  wire logic                       sample_valid,
  output logic                            sample_ready,
  input  wire logic [SEL_W-1:0]           sample_channel,
  input  wire logic [DATA_W-1:0]          sample_data,
  // process image from the coupler
  input  wire logic [NUM_CH*BYTE_W-1:0]   channel_control_byte,
  input  wire logic [NUM_CH*DATA_W-1:0]   channel_output_word,
  // process image to the coupler
  output logic      [NUM_CH*BYTE_W-1:0]   channel_status_byte,
  output logic      [NUM_CH*DATA_W-1:0]   channel_input_word
);

  // ****************************************************************
  // helpers
  // ****************************************************************
  function automatic logic signed [31:0] scale(
    input logic [DATA_W-1:0] x,
    input logic [DATA_W-1:0] g,
    input logic [DATA_W-1:0] o);
    logic signed [32:0] p;
    logic signed [32:0] sh;
    p     = $signed({{17{x[15]}}, x}) * $signed({17'h00000, g});
    sh    = p >>> GAIN_SHIFT;
    scale = sh[31:0] + {{16{o[15]}}, o};
  endfunction

  // returns {over, under, value}
  function automatic logic [17:0] saturate(
    input logic signed [31:0] v,
    input logic               prot);
    saturate = {2'b00, v[15:0]};
    if (v > SAT_MAX)
    begin
      saturate = {2'b10, prot ? SAT_MAX[15:0] : v[15:0]};
    end
    else if (v < SAT_MIN)
    begin
      saturate = {2'b01, prot ? SAT_MIN[15:0] : v[15:0]};
    end
  endfunction

  function automatic logic [3:0] cutoff_shift(input logic [DATA_W-1:0] c);
    if (c >= CUT_FAST)
    begin
      cutoff_shift = SHIFT_FAST;
    end
    else if (c >= CUT_MID)
    begin
      cutoff_shift = SHIFT_MID;
    end
    else if (c >= CUT_SLOW)
    begin
      cutoff_shift = SHIFT_SLOW;
    end
    else
    begin
      cutoff_shift = SHIFT_MIN;
    end
  endfunction

  function automatic logic [1:0] limit_state(
    input logic              en,
    input logic [DATA_W-1:0] v,
    input logic [DATA_W-1:0] t);
    if (!en)
    begin
      limit_state = LIM_OFF;
    end
    else if ($signed(v) > $signed(t))
    begin
      limit_state = LIM_ABOVE;
    end
    else
    begin
      limit_state = LIM_BELOW;
    end
  endfunction

  // ****************************************************************
  // storage
  // ****************************************************************
  logic [DATA_W-1:0] feature     [NUM_CH];
  logic [DATA_W-1:0] user_offset [NUM_CH];
  logic [DATA_W-1:0] user_gain   [NUM_CH];
  logic [DATA_W-1:0] thresh_one  [NUM_CH];
  logic [DATA_W-1:0] thresh_two  [NUM_CH];
  logic [DATA_W-1:0] cutoff      [NUM_CH];
  logic [DATA_W-1:0] filt_state  [NUM_CH];
  logic [DATA_W-1:0] in_word     [NUM_CH];
  logic [1:0]        lim_one     [NUM_CH];
  logic [1:0]        lim_two     [NUM_CH];
  logic [31:0]       wdog_cnt    [NUM_CH];
  logic [NUM_CH-1:0] over_flag;
  logic [NUM_CH-1:0] under_flag;
  logic [NUM_CH-1:0] err_flag;
  logic [NUM_CH-1:0] ack_flag;

  // ****************************************************************
  // sample buffer
  // ****************************************************************
  logic                    f_valid;
  logic                    f_ready;
  logic                    take;
  logic [SEL_W+DATA_W-1:0] f_data;

  // config writes stall the drain so one sample sees one setting
  assign f_ready = !cfg_wr;
  assign take    = f_valid && f_ready;

  aip_fifo #(
    .WIDTH (SEL_W + DATA_W),
    .DEPTH (FIFO_DEPTH)
  ) u_fifo (
    .clk_sys   (clk_sys),
    .reset_n   (reset_n),
    .in_valid  (sample_valid),
    .in_ready  (sample_ready),
    .in_data   ({sample_channel, sample_data}),
    .out_valid (f_valid),
    .out_ready (f_ready),
    .out_data  (f_data)
  );

  // ****************************************************************
  // value path
  // ****************************************************************
  logic [SEL_W-1:0]  ch;
  logic [DATA_W-1:0] feat;
  logic [DATA_W-1:0] cal_val;
  logic [DATA_W-1:0] usr_val;
  logic [DATA_W-1:0] next_filt;
  logic [DATA_W-1:0] next_word;
  logic              next_over;
  logic              next_under;

  always_comb
  begin
    logic [17:0]        sat;
    logic signed [16:0] diff;
    logic signed [16:0] step;
    logic signed [16:0] sum;
    logic [DATA_W-1:0]  mag;
    logic [DATA_W-1:0]  fmt;
    sat        = '0;
    diff       = '0;
    step       = '0;
    sum        = '0;
    mag        = '0;
    fmt        = '0;
    ch         = f_data[SEL_W+DATA_W-1:DATA_W];
    feat       = feature[ch];
    next_over  = 1'b0;
    next_under = 1'b0;
    cal_val    = f_data[DATA_W-1:0];
    if (feat[FB_FACT_SCALE])
    begin
      sat        = saturate(scale(f_data[DATA_W-1:0], FACT_GAIN,
                                  FACT_OFFSET), feat[FB_OVR_PROT]);
      cal_val    = sat[15:0];
      next_over  = sat[17];
      next_under = sat[16];
    end
    usr_val = cal_val;
    if (feat[FB_USER_SCALE])
    begin
      sat        = saturate(scale(cal_val, user_gain[ch], user_offset[ch]),
                            feat[FB_OVR_PROT]);
      usr_val    = sat[15:0];
      next_over  = next_over || sat[17];
      next_under = next_under || sat[16];
    end
    next_filt = usr_val;
    if (feat[FB_FILTER])
    begin
      // shift of one or more keeps the sum inside 16 bits
      diff      = $signed({usr_val[15], usr_val})
                  - $signed({filt_state[ch][15], filt_state[ch]});
      step      = diff >>> cutoff_shift(cutoff[ch]);
      sum       = $signed({filt_state[ch][15], filt_state[ch]}) + step;
      next_filt = sum[15:0];
    end
    fmt = next_filt;
    if (feat[FB_SIGN_MAG])
    begin
      mag = -next_filt;
      if (!next_filt[15])
      begin
        fmt = next_filt;
      end
      else if (next_filt == SAT_MIN[15:0])
      begin
        fmt = SM_MIN_CODE;
      end
      else
      begin
        fmt = {1'b1, mag[14:0]};
      end
    end
    // low three bits become two zeros and the over flag in the alternative format
    next_word = fmt;
    if (feat[FB_ALT_FORMAT])
    begin
      next_word = {fmt[15:3], 2'b00, next_over};
    end
  end

  // ****************************************************************
  // configuration registers
  // ****************************************************************
  always_ff @(posedge clk_sys or negedge reset_n)
  begin
    if (!reset_n)
    begin
      for (int i = 0; i < NUM_CH; i++)
      begin
        feature[i]     <= FEATURE_RESET;
        user_offset[i] <= USER_OFFSET_RESET;
        user_gain[i]   <= USER_GAIN_RESET;
        thresh_one[i]  <= THRESH_RESET;
        thresh_two[i]  <= THRESH_RESET;
        cutoff[i]      <= EIGHT_CH ? CUTOFF_RESET_8CH
                                   : CUTOFF_RESET_4CH;
      end
    end
    else if (cfg_wr)
    begin
      unique case (cfg_index)
        REG_FEATURE:     feature[cfg_channel]     <= cfg_wdata
                                                     & FEATURE_MASK;
        REG_USER_OFFSET: user_offset[cfg_channel] <= cfg_wdata;
        REG_USER_GAIN:   user_gain[cfg_channel]   <= cfg_wdata;
        REG_THRESH_ONE:  thresh_one[cfg_channel]  <= cfg_wdata;
        REG_THRESH_TWO:  thresh_two[cfg_channel]  <= cfg_wdata;
        REG_CUTOFF:      cutoff[cfg_channel]      <= cfg_wdata;
        default:         ;
      endcase
    end
  end

  always_ff @(posedge clk_sys or negedge reset_n)
  begin
    if (!reset_n)
    begin
      cfg_rdata  <= '0;
      cfg_rvalid <= 1'b0;
    end
    else
    begin
      cfg_rvalid <= cfg_rd;
      if (cfg_rd)
      begin
        unique case (cfg_index)
          REG_FEATURE:     cfg_rdata <= feature[cfg_channel];
          REG_USER_OFFSET: cfg_rdata <= user_offset[cfg_channel];
          REG_USER_GAIN:   cfg_rdata <= user_gain[cfg_channel];
          REG_THRESH_ONE:  cfg_rdata <= thresh_one[cfg_channel];
          REG_THRESH_TWO:  cfg_rdata <= thresh_two[cfg_channel];
          REG_CUTOFF:      cfg_rdata <= cutoff[cfg_channel];
          default:         cfg_rdata <= '0;
        endcase
      end
    end
  end

  // ****************************************************************
  // channel results
  // ****************************************************************
  always_ff @(posedge clk_sys or negedge reset_n)
  begin
    if (!reset_n)
    begin
      for (int i = 0; i < NUM_CH; i++)
      begin
        filt_state[i] <= '0;
        in_word[i]    <= '0;
        lim_one[i]    <= LIM_OFF;
        lim_two[i]    <= LIM_OFF;
      end
      over_flag  <= '0;
      under_flag <= '0;
    end
    else if (take)
    begin
      filt_state[ch] <= next_filt;
      over_flag[ch]  <= next_over;
      under_flag[ch] <= next_under;
      lim_one[ch] <= limit_state(feat[FB_LIMIT_ONE], next_filt,
                                 thresh_one[ch]);
      lim_two[ch] <= limit_state(feat[FB_LIMIT_TWO], next_filt,
                                 thresh_two[ch]);
      // word frozen while the channel is in register communication
      if (!channel_control_byte[ch*BYTE_W+CB_REG_SEL])
      begin
        in_word[ch] <= next_word;
      end
    end
  end

  // ****************************************************************
  // watchdog and mode acknowledge
  // ****************************************************************
  always_ff @(posedge clk_sys or negedge reset_n)
  begin
    if (!reset_n)
    begin
      for (int i = 0; i < NUM_CH; i++)
      begin
        wdog_cnt[i] <= '0;
      end
      err_flag <= '0;
      ack_flag <= '0;
    end
    else
    begin
      for (int i = 0; i < NUM_CH; i++)
      begin
        ack_flag[i] <= channel_control_byte[i*BYTE_W+CB_REG_SEL];
        if (take && (ch == SEL_W'(i)))
        begin
          wdog_cnt[i] <= '0;
          err_flag[i] <= 1'b0;
        end
        else if (!feature[i][FB_WATCHDOG])
        begin
          wdog_cnt[i] <= '0;
          err_flag[i] <= 1'b0;
        end
        else if (wdog_cnt[i] >= WDOG_LIMIT - 1)
        begin
          err_flag[i] <= 1'b1;
        end
        else
        begin
          wdog_cnt[i] <= wdog_cnt[i] + 1'b1;
        end
      end
    end
  end

  // ****************************************************************
  // process image
  // ****************************************************************
  always_comb
  begin
    for (int i = 0; i < NUM_CH; i++)
    begin
      channel_input_word[i*DATA_W +: DATA_W]  = in_word[i];
      channel_status_byte[i*BYTE_W +: BYTE_W] =
        {ack_flag[i], err_flag[i], lim_two[i], lim_one[i],
         over_flag[i], under_flag[i]};
    end
  end

endmodule
`default_nettype wire

// ### core/aip_fifo.sv
`timescale 1ns/1ps
`default_nettype none
module aip_fifo
  import aip_pkg::*;
#(
  parameter int WIDTH = 18,
  parameter int DEPTH = FIFO_DEPTH
)
(
  // clock and reset
  input  wire logic             clk_sys,
  input  wire logic             reset_n,
  // fill side
  input  wire logic             in_valid,
  output logic                  in_ready,
  input  wire logic [WIDTH-1:0] in_data,
  // drain side
  output logic                  out_valid,
  input  wire logic             out_ready,
  output logic      [WIDTH-1:0] out_data
);

  localparam int PW = $clog2(DEPTH);

  logic [WIDTH-1:0] mem [DEPTH];
  logic [PW:0]      wr_ptr;
  logic [PW:0]      rd_ptr;
  logic             push;
  logic             pop;

  assign in_ready  = (wr_ptr[PW-1:0] != rd_ptr[PW-1:0])
                     || (wr_ptr[PW] == rd_ptr[PW]);
  assign out_valid = (wr_ptr != rd_ptr);
  assign push      = in_valid && in_ready;
  assign pop       = out_valid && out_ready;
  assign out_data  = mem[rd_ptr[PW-1:0]];

  always_ff @(posedge clk_sys)
  begin
    if (push)
    begin
      mem[wr_ptr[PW-1:0]] <= in_data;
    end
  end

  always_ff @(posedge clk_sys or negedge reset_n)
  begin
    if (!reset_n)
    begin
      wr_ptr <= '0;
      rd_ptr <= '0;
    end
    else
    begin
      if (push)
      begin
        wr_ptr <= wr_ptr + 1'b1;
      end
      if (pop)
      begin
        rd_ptr <= rd_ptr + 1'b1;
      end
    end
  end

endmodule
`default_nettype wire

// ### core/aip_pkg.sv
package aip_pkg;

  // ****************************************************************
  // widths and sizes
  // ****************************************************************
  localparam int DATA_W     = 16;
  localparam int BYTE_W     = 8;
  localparam int IDX_W      = 6;
  localparam int FIFO_DEPTH = 8;

  // ****************************************************************
  // configuration register numbers
  // ****************************************************************
  localparam logic [IDX_W-1:0] REG_FEATURE     = 6'h20;
  localparam logic [IDX_W-1:0] REG_USER_OFFSET = 6'h21;
  localparam logic [IDX_W-1:0] REG_USER_GAIN   = 6'h22;
  localparam logic [IDX_W-1:0] REG_THRESH_ONE  = 6'h23;
  localparam logic [IDX_W-1:0] REG_THRESH_TWO  = 6'h24;
  localparam logic [IDX_W-1:0] REG_CUTOFF      = 6'h25;

  // ****************************************************************
  // channel_feature_control fields
  // ****************************************************************
  localparam int FB_USER_SCALE = 0;
  localparam int FB_FACT_SCALE = 1;
  localparam int FB_WATCHDOG   = 2;
  localparam int FB_SIGN_MAG   = 3;
  localparam int FB_ALT_FORMAT = 4;
  localparam int FB_OVR_PROT   = 8;
  localparam int FB_LIMIT_ONE  = 9;
  localparam int FB_LIMIT_TWO  = 10;
  localparam int FB_FILTER     = 11;
  localparam logic [DATA_W-1:0] FEATURE_MASK  = 16'h0F1F;
  localparam logic [DATA_W-1:0] FEATURE_RESET = 16'h0906;

  // ****************************************************************
  // value register resets and scaling
  // ****************************************************************
  localparam logic [DATA_W-1:0] USER_OFFSET_RESET = 16'h0000;
  localparam logic [DATA_W-1:0] USER_GAIN_RESET   = 16'h0100;
  localparam logic [DATA_W-1:0] THRESH_RESET      = 16'h0000;
  localparam logic [DATA_W-1:0] CUTOFF_RESET_4CH  = 16'h00C8;
  localparam logic [DATA_W-1:0] CUTOFF_RESET_8CH  = 16'h0064;
  localparam int                GAIN_SHIFT        = 8;
  localparam logic signed [31:0] SAT_MAX = 32'sh00007FFF;
  localparam logic signed [31:0] SAT_MIN = 32'shFFFF8000;
  localparam logic [DATA_W-1:0] SM_MIN_CODE = 16'hFFFF;

  // ****************************************************************
  // filter cut-off bands (Hz) and their shift
  // ****************************************************************
  localparam logic [DATA_W-1:0] CUT_FAST = 16'h03E8;
  localparam logic [DATA_W-1:0] CUT_MID  = 16'h00C8;
  localparam logic [DATA_W-1:0] CUT_SLOW = 16'h0064;
  localparam logic [3:0] SHIFT_FAST = 4'h1;
  localparam logic [3:0] SHIFT_MID  = 4'h2;
  localparam logic [3:0] SHIFT_SLOW = 4'h3;
  localparam logic [3:0] SHIFT_MIN  = 4'h4;

  // ****************************************************************
  // status and control byte fields
  // ****************************************************************
  localparam int CB_REG_SEL = 7;
  localparam int SB_ACK     = 7;
  localparam int SB_ERROR   = 6;
  localparam int SB_LIM_TWO = 4;
  localparam int SB_LIM_ONE = 2;
  localparam int SB_OVER    = 1;
  localparam int SB_UNDER   = 0;
  localparam logic [1:0] LIM_OFF   = 2'h0;
  localparam logic [1:0] LIM_BELOW = 2'h1;
  localparam logic [1:0] LIM_ABOVE = 2'h2;

  // ****************************************************************
  // timing
  // ****************************************************************
  localparam int CLK_KHZ     = 250000;
  localparam int WDOG_MS     = 100;
  localparam int WDOG_CYCLES = WDOG_MS * CLK_KHZ;

endpackage

// ### tb/aip_core_asserts.sv
`timescale 1ns/1ps
`default_nettype none
// ****************************************
// process image and register port checks
// ****************************************
module aip_core_checker
  import aip_pkg::*;
#(
  parameter int NUM_CH = 4
)
(
  // clock and reset
  input wire logic                     clk_sys,
  input wire logic                     reset_n,
  // register access
  input wire logic                     cfg_rd,
  input wire logic [IDX_W-1:0]         cfg_index,
  input wire logic [DATA_W-1:0]        cfg_rdata,
  input wire logic                     cfg_rvalid,
  // process image
  input wire logic [NUM_CH*BYTE_W-1:0] channel_control_byte,
  input wire logic [NUM_CH*BYTE_W-1:0] channel_status_byte,
  input wire logic [NUM_CH*DATA_W-1:0] channel_input_word
);
  default clocking cb @(posedge clk_sys); endclocking
  default disable iff (!reset_n);

  property p_rd_answer;
    cfg_rd |=> cfg_rvalid;
  endproperty
  a_rd_answer: assert property (p_rd_answer)
    else $error("read strobe got no answer");
  property p_rvalid_cause;
    cfg_rvalid |-> $past(cfg_rd);
  endproperty
  a_rvalid_cause: assert property (p_rvalid_cause)
    else $error("answer without a read");
  property p_rdata_hold;
    !cfg_rd |=> $stable(cfg_rdata);
  endproperty
  a_rdata_hold: assert property (p_rdata_hold)
    else $error("read data moved without a read");
  property p_unused_zero;
    cfg_rd && cfg_index == REG_FEATURE |=> (cfg_rdata & 16'hF0E0) == 16'h0000;
  endproperty
  a_unused_zero: assert property (p_unused_zero)
    else $error("unused feature bits read nonzero");
  property p_unmapped;
    cfg_rd && (cfg_index < 6'h20 || cfg_index > 6'h25)
      |=> cfg_rdata == 16'h0000;
  endproperty
  a_unmapped: assert property (p_unmapped)
    else $error("unmapped read not zero");
  property p_ack_copy;
    $past(reset_n) |->
      channel_status_byte[SB_ACK] == $past(channel_control_byte[CB_REG_SEL]);
  endproperty
  a_ack_copy: assert property (p_ack_copy)
    else $error("status bit 7 does not follow control bit 7");
  property p_word_held;
    channel_control_byte[CB_REG_SEL] |=> $stable(channel_input_word[15:0]);
  endproperty
  a_word_held: assert property (p_word_held)
    else $error("input word moved outside process data mode");
  property p_limit_code;
    channel_status_byte[5:4] != 2'h3 && channel_status_byte[3:2] != 2'h3;
  endproperty
  a_limit_code: assert property (p_limit_code)
    else $error("illegal limit state code");
endmodule

bind aip_core aip_core_checker #(.NUM_CH(NUM_CH)) i_aip_chk (
  .clk_sys              (clk_sys),
  .reset_n              (reset_n),
  .cfg_rd               (cfg_rd),
  .cfg_index            (cfg_index),
  .cfg_rdata            (cfg_rdata),
  .cfg_rvalid           (cfg_rvalid),
  .channel_control_byte (channel_control_byte),
  .channel_status_byte  (channel_status_byte),
  .channel_input_word   (channel_input_word)
);
`default_nettype wire

// ### tb/aip_coupler_model.sv
`timescale 1ns/1ps
`default_nettype none
// ****************************************
// coupler side of the process image
// ****************************************
module aip_coupler_model
  import aip_pkg::*;
(
  // clock and mode request
  input  wire logic                clk_sys,
  input  wire logic [3:0]          reg_sel,
  // input image
  input  wire logic [4*BYTE_W-1:0] channel_status_byte,
  input  wire logic [4*DATA_W-1:0] channel_input_word,
  // output image
  output logic      [4*BYTE_W-1:0] channel_control_byte,
  output logic      [4*DATA_W-1:0] channel_output_word,
  // coupler maps
  output logic      [4*DATA_W-1:0] compact_image,
  output logic      [8*DATA_W-1:0] full_image
);
  logic [DATA_W-1:0] tick = 16'h0000;

  // compact, and complete little-endian with word alignment
  always_comb
  begin
    for (int i = 0; i < 4; i++)
    begin
      compact_image[i*16 +: 16] =
        channel_input_word[i*16 +: 16];
      full_image[i*32 +: 16] =
        {8'h00, channel_status_byte[i*8 +: 8]};
      full_image[i*32+16 +: 16] = channel_input_word[i*16 +: 16];
    end
  end
  always @(posedge clk_sys)
  begin
    tick <= tick + 16'h0001;
    for (int i = 0; i < 4; i++)
    begin
      // bit 7 clear asks for process data mode
      channel_control_byte[i*8 +: 8] <= {reg_sel[i], 7'h00};
      // output words mean nothing; keep them moving so misuse shows
      channel_output_word[i*16 +: 16] <= tick ^ 16'(i);
    end
  end
endmodule
`default_nettype wire

// ### tb/analog_input_process_image_config_tb_top.sv
`timescale 1ns/1ps
`default_nettype none
module analog_input_process_image_config_tb_top
  import aip_pkg::*;
;
  typedef struct packed {
    logic [15:0] f, g, o, t, x, w, s;
  } aip_row_s;
  // feature, gain, offset, thresholds, sample, word, status
  aip_row_s rows [10] = '{
    '{16'h0106, 16'h0100, 16'h0000, 16'h0000, 16'h1234, 16'h1234, 16'h0000},
    '{16'h0107, 16'h0200, 16'h0010, 16'h0000, 16'h0100, 16'h0210, 16'h0000},
    '{16'h010E, 16'h0100, 16'h0000, 16'h0000, 16'hFFFB, 16'h8005, 16'h0000},
    '{16'h0116, 16'h0100, 16'h0000, 16'h0000, 16'h1237, 16'h1230, 16'h0000},
    '{16'h0107, 16'h0400, 16'h0000, 16'h0000, 16'h4000, 16'h7FFF, 16'h0002},
    '{16'h0107, 16'h0400, 16'h0000, 16'h0000, 16'hC000, 16'h8000, 16'h0001},
    '{16'h0007, 16'h0400, 16'h0000, 16'h0000, 16'h4000, 16'h0000, 16'h0002},
    '{16'h0306, 16'h0100, 16'h0000, 16'h0100, 16'h0200, 16'h0200, 16'h0008},
    '{16'h0306, 16'h0100, 16'h0000, 16'h0100, 16'h0100, 16'h0100, 16'h0004},
    '{16'h0706, 16'h0100, 16'h0000, 16'h0100, 16'h0050, 16'h0050, 16'h0014}};
  logic [15:0] rst_val [6] = '{16'h0906, 16'h0000, 16'h0100,
                               16'h0000, 16'h0000, 16'h00C8};
  logic              clk_sys = 1'b0;
  logic              reset_n = 1'b0;
  logic              cfg_wr = 1'b0;
  logic              cfg_rd = 1'b0;
  logic [1:0]        cfg_channel = 2'h0;
  logic [IDX_W-1:0]  cfg_index = 6'h00;
  logic [DATA_W-1:0] cfg_wdata = 16'h0000;
  logic [DATA_W-1:0] cfg_rdata;
  logic              cfg_rvalid;
  logic              sample_valid = 1'b0;
  logic              sample_ready;
  logic [1:0]        sample_channel = 2'h0;
  logic [DATA_W-1:0] sample_data = 16'h0000;
  logic [3:0]        reg_sel = 4'h0;
  logic [31:0]       ctrl_b;
  logic [63:0]       out_w;
  logic [31:0]       stat_b;
  logic [63:0]       in_w;
  logic [63:0]       in_hi;
  logic [63:0]       cmp_img;
  logic [127:0]      full_img;
  int                n_mismatch = 0;
  int                samples_checked = 0;
  int                cycles = 0;

  // short watchdog so it trips within the run
  aip_core #(.WDOG_LIMIT(20)) i_dut (
    .clk_sys(clk_sys), .reset_n(reset_n),
    .cfg_wr(cfg_wr), .cfg_rd(cfg_rd), .cfg_channel(cfg_channel),
    .cfg_index(cfg_index), .cfg_wdata(cfg_wdata),
    .cfg_rdata(cfg_rdata), .cfg_rvalid(cfg_rvalid),
    .sample_valid(sample_valid), .sample_ready(sample_ready),
    .sample_channel(sample_channel), .sample_data(sample_data),
    .channel_control_byte(ctrl_b), .channel_output_word(out_w),
    .channel_status_byte(stat_b), .channel_input_word(in_w));
  // high half of an eight-channel unit, own image
  aip_core #(.WDOG_LIMIT(20), .EIGHT_CH(1'b1)) i_dut_hi (
    .clk_sys(clk_sys), .reset_n(reset_n),
    .cfg_wr(cfg_wr), .cfg_rd(cfg_rd), .cfg_channel(cfg_channel),
    .cfg_index(cfg_index), .cfg_wdata(cfg_wdata),
    .cfg_rdata(), .cfg_rvalid(),
    .sample_valid(sample_valid), .sample_ready(),
    .sample_channel(sample_channel), .sample_data(sample_data),
    .channel_control_byte(ctrl_b), .channel_output_word(out_w),
    .channel_status_byte(), .channel_input_word(in_hi));
  aip_coupler_model i_coupler (
    .clk_sys(clk_sys), .reg_sel(reg_sel),
    .channel_status_byte(stat_b), .channel_input_word(in_w),
    .channel_control_byte(ctrl_b), .channel_output_word(out_w),
    .compact_image(cmp_img), .full_image(full_img));

  always #2 clk_sys = ~clk_sys;
  always @(posedge clk_sys)
  begin
    cycles++;
    if (cycles == 3000)
    begin
      n_mismatch++;
      finish_test();
    end
  end

  // ****************************************
  // bus and compare tasks
  // ****************************************
  task automatic chk(input string what, input logic [15:0] exp,
                     input logic [15:0] got);
    samples_checked++;
    if (got !== exp)
    begin
      n_mismatch++;
      $display("mismatch %s expected %h seen %h", what, exp, got);
    end
  endtask
  task automatic wr(input logic [1:0] ch, input logic [5:0] idx,
                    input logic [15:0] d);
    @(posedge clk_sys);
    cfg_wr <= 1'b1;
    cfg_channel <= ch;
    cfg_index <= idx;
    cfg_wdata <= d;
    @(posedge clk_sys);
    cfg_wr <= 1'b0;
  endtask
  task automatic rd(input logic [1:0] ch, input logic [5:0] idx,
                    input logic [15:0] exp);
    @(posedge clk_sys);
    cfg_rd <= 1'b1;
    cfg_channel <= ch;
    cfg_index <= idx;
    @(posedge clk_sys);
    cfg_rd <= 1'b0;
    #1;
    chk("rvalid", 16'h0001, {15'h0000, cfg_rvalid});
    chk("rdata", exp, cfg_rdata);
  endtask
  // drain may lag the push by a few edges
  task automatic push(input logic [1:0] ch, input logic [15:0] x);
    @(posedge clk_sys);
    sample_valid <= 1'b1;
    sample_channel <= ch;
    sample_data <= x;
    @(posedge clk_sys);
    sample_valid <= 1'b0;
    repeat (3) @(posedge clk_sys);
    #1;
  endtask
  task automatic finish_test();
    $display("checked %0d mismatches %0d", samples_checked, n_mismatch);
    if (n_mismatch == 0 && samples_checked > 0)
      $display("ALL TESTS PASSED");
    else
      $display("TESTS FAILED");
    $finish;
  endtask

  // ****************************************
  // main sequence
  // ****************************************
  initial
  begin
    repeat (10) @(posedge clk_sys);
    reset_n <= 1'b1;
    foreach (rows[i])
    begin
      wr(2'h0, REG_FEATURE, rows[i].f);
      wr(2'h0, REG_USER_GAIN, rows[i].g);
      wr(2'h0, REG_USER_OFFSET, rows[i].o);
      wr(2'h0, REG_THRESH_ONE, rows[i].t);
      wr(2'h0, REG_THRESH_TWO, rows[i].t);
      push(2'h0, rows[i].x);
      chk("word", rows[i].w, in_w[15:0]);
      chk("status", rows[i].s, {10'h000, stat_b[5:0]});
    end
    wr(2'h1, REG_FEATURE, 16'hFFFF);
    rd(2'h1, REG_FEATURE, 16'h0F1F);
    rd(2'h1, 6'h26, 16'h0000);
    @(posedge clk_sys);
    reg_sel <= 4'h1;
    push(2'h0, 16'h0777);
    chk("held word", 16'h0050, in_w[15:0]);
    chk("ack", 16'h0001, {15'h0000, stat_b[7]});
    chk("full map", 16'h00A8, full_img[15:0]);
    chk("compact map", 16'h0050, cmp_img[15:0]);
    @(posedge clk_sys);
    reg_sel <= 4'h0;
    // unmapped writes every cycle stall the drain and must be ignored
    wr(2'h3, REG_FEATURE, 16'h0106);
    @(posedge clk_sys);
    cfg_wr <= 1'b1;
    cfg_channel <= 2'h3;
    cfg_index <= 6'h3F;
    for (int i = 0; i < 8; i++)
    begin
      @(posedge clk_sys);
      sample_valid <= 1'b1;
      sample_channel <= 2'h3;
      sample_data <= 16'h0010 + 16'(i);
    end
    @(posedge clk_sys);
    sample_valid <= 1'b0;
    #1;
    chk("full", 16'h0000, {15'h0000, sample_ready});
    @(posedge clk_sys);
    cfg_wr <= 1'b0;
    repeat (12) @(posedge clk_sys);
    #1;
    chk("drained", 16'h0017, in_w[63:48]);
    chk("empty", 16'h0001, {15'h0000, sample_ready});
    rd(2'h3, REG_FEATURE, 16'h0106);
    @(posedge clk_sys);
    reset_n <= 1'b0;
    repeat (3) @(posedge clk_sys);
    reset_n <= 1'b1;
    foreach (rst_val[i])
      rd(2'h1, REG_FEATURE + 6'(i), rst_val[i]);
    push(2'h1, 16'h0100);
    chk("filtered", 16'h0040, in_w[31:16]);
    chk("filtered hi", 16'h0020, in_hi[31:16]);
    repeat (10) @(posedge clk_sys);
    #1;
    chk("wdog on", 16'h0001, {15'h0000, stat_b[22]});
    wr(2'h2, REG_FEATURE, 16'h0902);
    repeat (2) @(posedge clk_sys);
    #1;
    chk("wdog off", 16'h0000, {15'h0000, stat_b[22]});
    finish_test();
  end
endmodule
`default_nettype wire
